/* File: rsmd_top.sv */
/*
  rsmd_top: rs485 extension of a uart. rts direction control from the
  transmitter, and 9-bit multidrop receive filtering with address match.
  assumes the uart core reports fifo writes, fifo and shift-register
  emptiness, and received characters with their ninth bit, all
  synchronous to clock.
*/
// Contract
// RULE_01: manual bit or flow control drives rts
// RULE_02: transmitter-owns-rts bit overrides other sources
// RULE_03: auto mode: rts low on write, high after
// RULE_04: software disables flow control before auto rts
// RULE_05: inversion: rts high while sending, low after
// RULE_06: lowest control bit enables 9-bit multidrop
// RULE_07: address character interrupts the controller
// RULE_08: software disables all flow control for multidrop
// RULE_09: software sets 9-bit, no detect, parity 111
// RULE_10: disabled receiver ignores data until address
// RULE_11: address sets parity error, fifo, line interrupt
// RULE_12: controller enables receiver only for own address
// RULE_13: enabled receiver flags parity error on address
// RULE_14: detect mode compares addresses, drops data, mismatches
// RULE_15: matching address enables receiver, pushed, interrupts
// RULE_16: mismatch disables receiver; match keeps parity bit
// RULE_17: receiver-off stops reception, pending char kept
// RULE_18: last bit sent means fifo and shifter empty
`timescale 1ns/1ps
module rsmd_top
   import rsmd_pkg::*;
(
   input wire logic clock, // 25 MHz system clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction, high for write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error for unmapped address
   input wire logic tx_fifo_wr, // host wrote a byte to the tx fifo
   input wire logic tx_fifo_empty, // tx fifo holds nothing
   input wire logic tx_shift_empty, // tx shifter idle after stop bit
   input wire logic flow_rts_n, // rts level from flow control logic
   input wire logic rx_valid, // one-cycle pulse, character received
   input wire logic [7:0] rx_data, // received character
   input wire logic rx_parity, // received ninth (parity) bit
   input wire logic rx_perr, // parity check result, non-multidrop
   output logic rx_push, // push strobe into the rx fifo
   output logic [7:0] rx_push_data, // byte pushed into the rx fifo
   output logic rx_push_perr, // parity error slot of the pushed byte
   output logic rts_n, // rts pin, active low
   output logic line_irq, // line status interrupt pulse
   output logic irq // level interrupt from masked events
);
   rsmd_state_type s_q; // registered state
   rsmd_state_type s_d; // next state
   logic setup_ph; // apb setup cycle
   logic access_done; // apb access completes this edge
   logic mapped; // address decodes to a register
   logic nine_bit; // multidrop mode
   logic detect_on; // auto address detection
   logic rx_on; // receiver enabled
   logic addr_match; // address equals stored character
   logic ls_event; // address accepted into fifo

   // read side and decode for the current apb address
   always_comb begin
      setup_ph = psel && !penable;
      access_done = psel && penable && s_q.pready;
      mapped = 1'b1;
      unique case (paddr)
         ADDR_EXTRA_FEATURES_CTRL,
         ADDR_MODEM_CONTROL_REG,
         ADDR_LINE_CONTROL_REG,
         ADDR_INTERRUPT_ENABLE_REG,
         ADDR_ENHANCED_FEATURES_REG,
         ADDR_SECOND_FLOW_STOP_CHAR,
         ADDR_FLOW_CTRL,
         ADDR_EVENT_STATUS,
         ADDR_EVENT_MASK,
         ADDR_BLOCK_STATE: mapped = 1'b1;
         default: mapped = 1'b0; // unmapped address answers with pslverr
      endcase
   end

   // next-state logic: bus first, then hardware events so that sets win
   always_comb begin
      s_d = s_q;
      s_d.push = '0; // push strobe lasts one cycle
      s_d.line_irq = 1'b0;
      ls_event = 1'b0;
      // apb: pready for exactly one cycle, so every transfer has one wait-free access
      s_d.pready = setup_ph;
      if (setup_ph) begin
         s_d.pslverr = !mapped;
         unique case (paddr)
            ADDR_EXTRA_FEATURES_CTRL: s_d.prdata = {24'h000000, s_q.extra_features_ctrl};
            ADDR_MODEM_CONTROL_REG: s_d.prdata = {24'h000000, s_q.modem_control_reg};
            ADDR_LINE_CONTROL_REG: s_d.prdata = {24'h000000, s_q.line_control_reg};
            ADDR_INTERRUPT_ENABLE_REG: s_d.prdata = {24'h000000, s_q.interrupt_enable_reg};
            ADDR_ENHANCED_FEATURES_REG: s_d.prdata = {24'h000000, s_q.enhanced_features_reg};
            ADDR_SECOND_FLOW_STOP_CHAR: s_d.prdata = {24'h000000, s_q.second_flow_stop_char};
            ADDR_FLOW_CTRL: s_d.prdata = {24'h000000, s_q.flow};
            ADDR_EVENT_STATUS: s_d.prdata = {29'h00000000, s_q.sts};
            ADDR_EVENT_MASK: s_d.prdata = {29'h00000000, s_q.msk};
            ADDR_BLOCK_STATE: s_d.prdata = {29'h00000000, s_q.irq, s_q.rts_n, s_q.tx_busy};
            default: s_d.prdata = 32'h00000000; // unmapped reads as zero
         endcase
      end
      if (access_done && pwrite && mapped) begin
         unique case (paddr)
            ADDR_EXTRA_FEATURES_CTRL: s_d.extra_features_ctrl = pwdata[7:0];
            ADDR_MODEM_CONTROL_REG: s_d.modem_control_reg = pwdata[7:0];
            ADDR_LINE_CONTROL_REG: s_d.line_control_reg = pwdata[7:0];
            ADDR_INTERRUPT_ENABLE_REG: s_d.interrupt_enable_reg = pwdata[7:0];
            ADDR_ENHANCED_FEATURES_REG: s_d.enhanced_features_reg = pwdata[7:0];
            ADDR_SECOND_FLOW_STOP_CHAR: s_d.second_flow_stop_char = pwdata[7:0];
            ADDR_FLOW_CTRL: s_d.flow = pwdata[7:0];
            ADDR_EVENT_MASK: s_d.msk = pwdata[EV_WIDTH-1:0];
            default: s_d.flow = s_d.flow; // status and state are read-only
         endcase
      end
      // read clears only the bits that were returned, so a new event survives
      if (access_done && !pwrite && paddr == ADDR_EVENT_STATUS) begin
         s_d.sts = s_q.sts & ~s_q.prdata[EV_WIDTH-1:0];
      end

      // receive filtering; uses the old enable, so a char arriving as
      // receiver_off is written still lands in the fifo
      nine_bit = s_q.extra_features_ctrl[NINE_BIT_POS]; // [RULE_06]
      detect_on = s_q.enhanced_features_reg[SPECIAL_DETECT_POS];
      rx_on = !s_q.extra_features_ctrl[RECEIVER_OFF_POS]; // [RULE_17]
      addr_match = (rx_data == s_q.second_flow_stop_char);
      if (rx_valid) begin
         s_d.push.data = rx_data;
         if (!nine_bit) begin
            // plain uart: pass with the core's parity check
            s_d.push.valid = rx_on; // [RULE_17]
            s_d.push.perr = rx_perr;
         end else if (!detect_on) begin
            if (rx_parity) begin
               // address: stored with parity error, enabled or not
               s_d.push.valid = 1'b1; // [RULE_11] [RULE_13]
               s_d.push.perr = 1'b1; // [RULE_11]
               ls_event = 1'b1; // [RULE_07]
            end else begin
               // data only while the controller keeps receiver on
               s_d.push.valid = rx_on; // [RULE_10]
               s_d.push.perr = 1'b0;
            end
         end else begin
            if (rx_parity && addr_match) begin
               s_d.extra_features_ctrl[RECEIVER_OFF_POS] = 1'b0; // [RULE_15]
               s_d.push.valid = 1'b1; // [RULE_15] [RULE_16]
               s_d.push.perr = rx_parity; // [RULE_16]
               ls_event = 1'b1; // [RULE_15]
            end else if (rx_parity) begin
               // foreign address: switch off and drop
               s_d.extra_features_ctrl[RECEIVER_OFF_POS] = 1'b1; // [RULE_16]
               s_d.sts[EV_ADDR_DROPPED_POS] = 1'b1;
            end else begin
               s_d.push.valid = rx_on; // [RULE_14]
               s_d.push.perr = 1'b0;
            end
         end
      end
      if (ls_event) begin
         s_d.sts[EV_ADDR_TAKEN_POS] = 1'b1; // [RULE_07]
         s_d.line_irq = s_q.interrupt_enable_reg[LINE_STATUS_IE_POS]; // [RULE_11]
      end

      // transmit busy: a fresh write wins over the empty condition
      if (tx_fifo_wr) begin
         s_d.tx_busy = 1'b1; // [RULE_03]
      end else if (tx_fifo_empty && tx_shift_empty) begin
         s_d.tx_busy = 1'b0; // [RULE_18]
         if (s_q.tx_busy) begin
            s_d.sts[EV_TX_DONE_POS] = 1'b1;
         end
      end

      // rts source select, taken from the next control values
      if (s_d.extra_features_ctrl[TRANSMITTER_OWNS_RTS_POS]) begin // [RULE_02]
         if (s_d.extra_features_ctrl[DIRECTION_POLARITY_INVERT_POS]) begin
            s_d.rts_n = s_d.tx_busy; // [RULE_05]
         end else begin
            s_d.rts_n = !s_d.tx_busy; // [RULE_03]
         end
      end else if (s_d.flow[HW_FLOW_EN_POS]) begin
         s_d.rts_n = flow_rts_n; // [RULE_01]
      end else begin
         s_d.rts_n = !s_d.modem_control_reg[MANUAL_RTS_POS]; // [RULE_01]
      end

      s_d.irq = |(s_d.sts & s_d.msk);
   end

   // state register; idle rts is high after reset
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         s_q <= '0;
         s_q.rts_n <= 1'b1;
         s_q.sts <= RESET_EVENTS;
         s_q.extra_features_ctrl <= RESET_BYTE;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign rx_push = s_q.push.valid;
   assign rx_push_data = s_q.push.data;
   assign rx_push_perr = s_q.push.perr;
   assign rts_n = s_q.rts_n;
   assign line_irq = s_q.line_irq;
   assign irq = s_q.irq;

   // checks
   property p_rts_manual;
      @(posedge clock) disable iff (sys_rst)
      (!s_q.extra_features_ctrl[TRANSMITTER_OWNS_RTS_POS] && !s_q.flow[HW_FLOW_EN_POS])
         |-> (rts_n == !s_q.modem_control_reg[MANUAL_RTS_POS]);
   endproperty
   a_rts_manual: assert property (p_rts_manual) else $error("rts not from manual bit"); // [RULE_01]

   property p_rts_flow;
      @(posedge clock) disable iff (sys_rst)
      (!s_q.extra_features_ctrl[TRANSMITTER_OWNS_RTS_POS] && s_q.flow[HW_FLOW_EN_POS])
         |-> (rts_n == $past(flow_rts_n));
   endproperty
   a_rts_flow: assert property (p_rts_flow) else $error("rts not from flow control"); // [RULE_01]

   property p_rts_assert;
      @(posedge clock) disable iff (sys_rst)
      (s_d.extra_features_ctrl[TRANSMITTER_OWNS_RTS_POS] && !s_d.extra_features_ctrl[DIRECTION_POLARITY_INVERT_POS]
         && tx_fifo_wr) |=> !rts_n;
   endproperty
   a_rts_assert: assert property (p_rts_assert) else $error("rts not low on write"); // [RULE_03]

   property p_rts_invert;
      @(posedge clock) disable iff (sys_rst)
      (s_d.extra_features_ctrl[TRANSMITTER_OWNS_RTS_POS] && s_d.extra_features_ctrl[DIRECTION_POLARITY_INVERT_POS]
         && tx_fifo_wr) |=> rts_n;
   endproperty
   a_rts_invert: assert property (p_rts_invert) else $error("inverted rts not high"); // [RULE_05]

   property p_rts_release;
      @(posedge clock) disable iff (sys_rst)
      (s_d.extra_features_ctrl[TRANSMITTER_OWNS_RTS_POS] && !s_d.extra_features_ctrl[DIRECTION_POLARITY_INVERT_POS]
         && !tx_fifo_wr && tx_fifo_empty && tx_shift_empty) |=> rts_n && !s_q.tx_busy;
   endproperty
   a_rts_release: assert property (p_rts_release) else $error("rts not released"); // [RULE_18]

   property p_drop_data;
      @(posedge clock) disable iff (sys_rst)
      (rx_valid && s_q.extra_features_ctrl[NINE_BIT_POS] && s_q.extra_features_ctrl[RECEIVER_OFF_POS] && !rx_parity)
         |=> !rx_push;
   endproperty
   a_drop_data: assert property (p_drop_data) else $error("data taken while off"); // [RULE_10]

   property p_addr_normal;
      @(posedge clock) disable iff (sys_rst)
      (rx_valid && s_q.extra_features_ctrl[NINE_BIT_POS] && !s_q.enhanced_features_reg[SPECIAL_DETECT_POS] && rx_parity)
         |=> rx_push && rx_push_perr && (line_irq == $past(s_q.interrupt_enable_reg[LINE_STATUS_IE_POS]));
   endproperty
   a_addr_normal: assert property (p_addr_normal) else $error("address not flagged"); // [RULE_11]

   property p_addr_enabled;
      @(posedge clock) disable iff (sys_rst)
      (rx_valid && s_q.extra_features_ctrl[NINE_BIT_POS] && !s_q.enhanced_features_reg[SPECIAL_DETECT_POS]
         && !s_q.extra_features_ctrl[RECEIVER_OFF_POS] && rx_parity)
         |=> rx_push && rx_push_perr && (rx_push_data == $past(rx_data));
   endproperty
   a_addr_enabled: assert property (p_addr_enabled) else $error("no error on address"); // [RULE_13]

   property p_match;
      @(posedge clock) disable iff (sys_rst)
      (rx_valid && s_q.extra_features_ctrl[NINE_BIT_POS] && s_q.enhanced_features_reg[SPECIAL_DETECT_POS] && rx_parity
         && rx_data == s_q.second_flow_stop_char) |=> rx_push && rx_push_perr && !s_q.extra_features_ctrl[RECEIVER_OFF_POS];
   endproperty
   a_match: assert property (p_match) else $error("matching address lost"); // [RULE_15]

   property p_mismatch;
      @(posedge clock) disable iff (sys_rst)
      (rx_valid && s_q.extra_features_ctrl[NINE_BIT_POS] && s_q.enhanced_features_reg[SPECIAL_DETECT_POS] && rx_parity
         && rx_data != s_q.second_flow_stop_char) |=> !rx_push && s_q.extra_features_ctrl[RECEIVER_OFF_POS];
   endproperty
   a_mismatch: assert property (p_mismatch) else $error("foreign address kept"); // [RULE_16]

   property p_addr_event;
      @(posedge clock) disable iff (sys_rst)
      (rx_valid && s_q.extra_features_ctrl[NINE_BIT_POS] && rx_parity && !s_q.enhanced_features_reg[SPECIAL_DETECT_POS])
         |=> s_q.sts[EV_ADDR_TAKEN_POS];
   endproperty
   a_addr_event: assert property (p_addr_event) else $error("address event missing"); // [RULE_07]

   // transmitter ownership: rts follows busy, whatever manual bit and flow say
   property p_rts_own;
      @(posedge clock) disable iff (sys_rst)
      (s_q.extra_features_ctrl[TRANSMITTER_OWNS_RTS_POS] && !s_q.extra_features_ctrl[DIRECTION_POLARITY_INVERT_POS])
         |-> (rts_n == !s_q.tx_busy);
   endproperty
   a_rts_own: assert property (p_rts_own) else $error("rts not owned"); // [RULE_02]

   property p_rts_own_inv;
      @(posedge clock) disable iff (sys_rst)
      (s_q.extra_features_ctrl[TRANSMITTER_OWNS_RTS_POS] && s_q.extra_features_ctrl[DIRECTION_POLARITY_INVERT_POS])
         |-> (rts_n == s_q.tx_busy);
   endproperty
   a_rts_own_inv: assert property (p_rts_own_inv) else $error("rts polarity wrong"); // [RULE_05]

   // plain uart path: receiver_off gates, otherwise the char passes as is
   property p_plain_off;
      @(posedge clock) disable iff (sys_rst)
      (rx_valid && !s_q.extra_features_ctrl[NINE_BIT_POS] && s_q.extra_features_ctrl[RECEIVER_OFF_POS]) |=> !rx_push;
   endproperty
   a_plain_off: assert property (p_plain_off) else $error("char taken while off"); // [RULE_17]

   property p_plain_pass;
      @(posedge clock) disable iff (sys_rst)
      (rx_valid && !s_q.extra_features_ctrl[NINE_BIT_POS] && !s_q.extra_features_ctrl[RECEIVER_OFF_POS])
         |=> rx_push && (rx_push_data == $past(rx_data)) && (rx_push_perr == $past(rx_perr));
   endproperty
   a_plain_pass: assert property (p_plain_pass) else $error("plain char altered"); // [RULE_06]

   // matching address raises the line interrupt when enabled
   property p_match_irq;
      @(posedge clock) disable iff (sys_rst)
      (rx_valid && s_q.extra_features_ctrl[NINE_BIT_POS] && s_q.enhanced_features_reg[SPECIAL_DETECT_POS] && rx_parity
         && rx_data == s_q.second_flow_stop_char) |=> (line_irq == $past(s_q.interrupt_enable_reg[LINE_STATUS_IE_POS]));
   endproperty
   a_match_irq: assert property (p_match_irq) else $error("match without interrupt"); // [RULE_15]

   // busy falls and tx done is flagged once both stages are empty
   property p_tx_done;
      @(posedge clock) disable iff (sys_rst)
      (s_q.tx_busy && !tx_fifo_wr && tx_fifo_empty && tx_shift_empty)
         |=> s_q.sts[EV_TX_DONE_POS] && !s_q.tx_busy;
   endproperty
   a_tx_done: assert property (p_tx_done) else $error("tx done not flagged"); // [RULE_18]

   // foreign address is flagged as dropped and never raises the line interrupt
   property p_drop_event;
      @(posedge clock) disable iff (sys_rst)
      (rx_valid && s_q.extra_features_ctrl[NINE_BIT_POS] && s_q.enhanced_features_reg[SPECIAL_DETECT_POS] && rx_parity
         && rx_data != s_q.second_flow_stop_char) |=> s_q.sts[EV_ADDR_DROPPED_POS] && !line_irq;
   endproperty
   a_drop_event: assert property (p_drop_event) else $error("drop not flagged"); // [RULE_16]
endmodule

/* File: rsmd_pkg.sv */
/*
  rsmd_pkg: shared constants and carrier types for the rs485 multidrop
  and rts direction block.
  assumes a 32-bit apb master and a byte-wide uart core around the block.
*/
package rsmd_pkg;
   // apb byte addresses
   localparam logic [7:0] ADDR_EXTRA_FEATURES_CTRL = 8'h00;
   localparam logic [7:0] ADDR_MODEM_CONTROL_REG = 8'h04;
   localparam logic [7:0] ADDR_LINE_CONTROL_REG = 8'h08;
   localparam logic [7:0] ADDR_INTERRUPT_ENABLE_REG = 8'h0C;
   localparam logic [7:0] ADDR_ENHANCED_FEATURES_REG = 8'h10;
   localparam logic [7:0] ADDR_SECOND_FLOW_STOP_CHAR = 8'h14;
   localparam logic [7:0] ADDR_FLOW_CTRL = 8'h18;
   localparam logic [7:0] ADDR_EVENT_STATUS = 8'h1C;
   localparam logic [7:0] ADDR_EVENT_MASK = 8'h20;
   localparam logic [7:0] ADDR_BLOCK_STATE = 8'h24;
   // extra_features_ctrl fields
   localparam int NINE_BIT_POS = 0;
   localparam int RECEIVER_OFF_POS = 1;
   localparam int TRANSMITTER_OWNS_RTS_POS = 4;
   localparam int DIRECTION_POLARITY_INVERT_POS = 5;
   // other fields
   localparam int MANUAL_RTS_POS = 1;       // modem_control_reg
   localparam int LINE_STATUS_IE_POS = 2;   // interrupt_enable_reg
   localparam int SPECIAL_DETECT_POS = 5;   // enhanced_features_reg
   localparam int HW_FLOW_EN_POS = 0;       // flow control register
   // event status bits
   localparam int EV_ADDR_TAKEN_POS = 0;
   localparam int EV_ADDR_DROPPED_POS = 1;
   localparam int EV_TX_DONE_POS = 2;
   localparam int EV_WIDTH = 3;
   // reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [EV_WIDTH-1:0] RESET_EVENTS = 3'h0;

   // receive character handed to the fifo
   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic perr;
   } rsmd_push_type;

   // whole state of the top module
   typedef struct packed {
      logic [7:0] extra_features_ctrl;
      logic [7:0] modem_control_reg;
      logic [7:0] line_control_reg;
      logic [7:0] interrupt_enable_reg;
      logic [7:0] enhanced_features_reg;
      logic [7:0] second_flow_stop_char;
      logic [7:0] flow;
      logic [EV_WIDTH-1:0] sts;
      logic [EV_WIDTH-1:0] msk;
      logic tx_busy;
      logic rts_n;
      logic irq;
      logic line_irq;
      rsmd_push_type push;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } rsmd_state_type;
endpackage

/* File: rsmd_uart_model.sv */
/*
  rsmd_uart_model: stand-in for the uart core and the rs485 stations.
  assumes the bench commands received characters and tx fifo writes.
*/
`timescale 1ns/1ps
module rsmd_uart_model
   import rsmd_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic send, // bench asks for one received char
   input wire logic [7:0] ch, // char to deliver
   input wire logic par, // ninth bit of that char
   input wire logic tx_wr, // host write into the tx fifo
   input wire logic [3:0] span, // cycles per char, prompt or slow
   output logic rx_valid, // char strobe
   output logic [7:0] rx_data, // char byte
   output logic rx_parity, // ninth bit
   output logic rx_perr, // parity check result
   output logic tx_fifo_empty, // fifo holds nothing
   output logic tx_shift_empty // shifter idle
);
   int cnt = 0; // cycles of tx work left
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_parity = 1'b0;
      rx_perr = 1'b0;
      tx_fifo_empty = 1'b1;
      tx_shift_empty = 1'b1;
   end
   // receive lines invert when idle, so stale data never looks valid
   always @(posedge clock) begin
      rx_valid <= send;
      rx_data <= send ? ch : ~rx_data;
      rx_parity <= send ? par : ~rx_parity;
      rx_perr <= send ? par : ~rx_perr;
   end
   // tx: fifo drains into the shifter, one char per span
   always @(posedge clock) begin
      int n;
      n = tx_wr ? cnt + int'(span) : (cnt > 0 ? cnt - 1 : 0);
      cnt <= n;
      tx_fifo_empty <= n <= int'(span);
      tx_shift_empty <= n == 0;
   end
endmodule

/* File: tb_rs485_multidrop_rts_control.sv */
/*
  tb_rs485_multidrop_rts_control: self-checking bench with a reference
  model of filtering, rts and events. assumes rsmd_top and the partner.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_rs485_multidrop_rts_control;
   import rsmd_pkg::*;
   logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0; // bus
   logic [7:0] paddr = 8'h00, ch = 8'h00, rx_data, rx_push_data; // bytes
   logic [31:0] pwdata = 32'h0, prdata, rdata; // words
   logic pready, pslverr, rerr, tx_fifo_empty, tx_shift_empty; // status
   logic tx_fifo_wr = 0, flow_rts_n = 1, send = 0, par = 0; // stimulus
   logic [3:0] span = 4'h3; // partner speed
   logic rx_valid, rx_parity, rx_perr, rx_push, rx_push_perr; // rx path
   logic rts_n, line_irq, irq; // outputs
   int fails = 0, compares = 0; // counters
   int efc, enhanced_features_reg, xo, ie, msk, sts = 0; // model copies of registers
   rsmd_top rsmd_top_i (.clock(clock), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .tx_fifo_wr(tx_fifo_wr), .tx_fifo_empty(tx_fifo_empty),
      .tx_shift_empty(tx_shift_empty), .flow_rts_n(flow_rts_n),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_parity(rx_parity),
      .rx_perr(rx_perr), .rx_push(rx_push), .rx_push_data(rx_push_data),
      .rx_push_perr(rx_push_perr), .rts_n(rts_n), .line_irq(line_irq), .irq(irq));
   rsmd_uart_model rsmd_uart_model_i (.clock(clock), .send(send), .ch(ch),
      .par(par), .tx_wr(tx_fifo_wr), .span(span), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_parity(rx_parity), .rx_perr(rx_perr),
      .tx_fifo_empty(tx_fifo_empty), .tx_shift_empty(tx_shift_empty));
   // 25 MHz clock
   initial begin
      forever #20 clock = ~clock;
   end
   // one apb transfer, waits for pready with a bound
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) fails++;
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input int d);
      apb(1'b1, a, 32'(d));
   endtask
   task automatic rd(input logic [7:0] a, input int e, input logic ee);
      apb(1'b0, a, 32'h0);
      `CHK(rdata, 32'(e))
      `CHK(rerr, ee)
   endtask
   // rts settles within two edges of its cause
   task automatic chk_rts(input logic e);
      repeat (2) @(posedge clock);
      @(negedge clock);
      `CHK(rts_n, e)
   endtask
   // one tx char with auto direction; inv is the polarity bit
   task automatic tx(input logic inv);
      int n;
      n = 0;
      @(posedge clock);
      tx_fifo_wr <= 1'b1;
      span <= 4'($urandom_range(1, 9));
      @(posedge clock);
      tx_fifo_wr <= 1'b0;
      @(negedge clock);
      `CHK(rts_n, inv)
      while (!(tx_fifo_empty && tx_shift_empty) && n < 50) begin
         if (tx_fifo_empty) `CHK(rts_n, inv)
         @(negedge clock);
         n++;
      end
      @(posedge clock);
      @(negedge clock);
      `CHK(rts_n, !inv)
      sts |= 4;
   endtask
   // one received char against the reference filter
   task automatic rx(input logic [7:0] d, input logic p);
      int push, li;
      push = !(efc & 2);
      li = 0;
      if ((efc & 1) && p) begin
         push = !enhanced_features_reg[5] || d == 8'(xo);
         efc = enhanced_features_reg[5] ? (push ? efc & ~2 : efc | 2) : efc;
         sts |= push ? 1 : 2;
         li = push && (ie & 4);
      end
      @(posedge clock);
      send <= 1'b1;
      ch <= d;
      par <= p;
      @(posedge clock);
      send <= 1'b0;
      @(posedge clock);
      @(negedge clock);
      `CHK(rx_push, 1'(push))
      `CHK(line_irq, 1'(li))
      if (push) begin
         `CHK(rx_push_data, d)
         `CHK(rx_push_perr, p)
      end
      // controller opens the receiver only for its own address
      if ((efc & 1) && !enhanced_features_reg[5] && p) begin
         efc = d == 8'(xo) ? efc & ~2 : efc | 2;
         wr(ADDR_EXTRA_FEATURES_CTRL, efc);
      end
   endtask
   task automatic summarize;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // watchdog, well beyond the expected run
   initial begin
      repeat (30000) @(posedge clock);
      fails++;
      summarize();
   end
   // main sequence
   initial begin
      int g, i, x;
      x = $urandom(32'hD865F4AE);
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      // reset values; state reads rts_n high
      for (i = 0; i <= 9; i++) rd(8'(4 * i), i == 9 ? 2 : 0, 1'b0);
      wr(ADDR_BLOCK_STATE, 32'hFF);
      rd(ADDR_BLOCK_STATE, 2, 1'b0);
      rd(8'h28, 0, 1'b1);
      wr(ADDR_MODEM_CONTROL_REG, 2);
      chk_rts(1'b0);
      wr(ADDR_FLOW_CTRL, 1);
      for (i = 0; i < 6; i++) begin
         x = $urandom;
         @(posedge clock);
         flow_rts_n <= x[0];
         chk_rts(x[0]);
      end
      @(posedge clock);
      flow_rts_n <= 1'b0;
      wr(ADDR_EXTRA_FEATURES_CTRL, 32'h10);
      chk_rts(1'b1);
      wr(ADDR_FLOW_CTRL, 0);
      wr(ADDR_EVENT_MASK, 4);
      msk = 4;
      tx(1'b0);
      wr(ADDR_EXTRA_FEATURES_CTRL, 32'h30);
      chk_rts(1'b0);
      tx(1'b1);
      `CHK(irq, 1'b1)
      rd(ADDR_EVENT_STATUS, sts, 1'b0);
      sts = 0;
      chk_rts(1'b0);
      `CHK(irq, 1'b0)
      wr(ADDR_LINE_CONTROL_REG, 32'h38);
      // modes: plain on/off, normal multidrop on/off, auto detect
      for (g = 0; g < 6; g++) begin
         efc = g < 2 ? 2 * g : 1 + 2 * (g % 2);
         enhanced_features_reg = g > 3 ? 32 : 0;
         xo = $urandom % 256;
         ie = $urandom % 2 * 4;
         msk = $urandom % 8;
         wr(ADDR_EXTRA_FEATURES_CTRL, efc);
         wr(ADDR_ENHANCED_FEATURES_REG, enhanced_features_reg);
         wr(ADDR_SECOND_FLOW_STOP_CHAR, xo);
         wr(ADDR_INTERRUPT_ENABLE_REG, ie);
         wr(ADDR_EVENT_MASK, msk);
         for (i = 0; i < 16; i++) begin
            x = $urandom;
            rx(x[1:0] == 0 ? 8'(xo) : x[15:8], x[2]);
         end
         rd(ADDR_EXTRA_FEATURES_CTRL, efc, 1'b0);
         `CHK(irq, 1'((sts & msk) != 0))
         rd(ADDR_EVENT_STATUS, sts, 1'b0);
         sts = 0;
         chk_rts(1'b0);
         `CHK(irq, 1'b0)
      end
      summarize();
   end
endmodule
